// File: rtl/pld_cfg.svh
// Constants of the configuration, security and preload logic
`ifndef PLD_CFG_SVH
`define PLD_CFG_SVH

// Register byte offsets
`define OFS_ROW 8'h00
`define OFS_DATA0 8'h04
`define OFS_DATA1 8'h08
`define OFS_DATA2 8'h0C
`define OFS_CMD 8'h10
`define OFS_RDATA0 8'h14
`define OFS_RDATA1 8'h18
`define OFS_RDATA2 8'h1C
`define OFS_STATUS 8'h20
`define OFS_OUTS 8'h24

// Command and status bit positions
`define CMD_PROGRAM 0
`define CMD_READ 1
`define ST_LOCK 0
`define ST_DENIED 1
`define ST_BAD_ROW 2
`define ST_POR 3
`define ST_PRELOAD 4
`define ST_REG_MODE 5

// Row map
`define ARRAY_ROWS 40
`define ROW_SIGNATURE 6'h28
`define ROW_CTRL 6'h3C
`define ROW_LOCK 6'h3D
`define ROW_ERASE 6'h3F
`define ROW_BITS 6
`define ARRAY_BITS 64

// Control word layout
`define CW_BITS 82
`define CW_POL_LSB 64
`define CW_CELL_LSB 72
`define CW_AC0 80
`define CW_SYNC 81
`define CELLS 8

// Erased (virgin) contents and reset values
`define ERASED_ROW 64'h0
`define ERASED_CW 82'h0
`define ROW_RESET 6'h00
`define PIN_RESET 8'hFF

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Power-up reset time
`define CLK_PERIOD_NS 10
`define POR_TIME_NS 10000
`define POR_CYCLES (`POR_TIME_NS / `CLK_PERIOD_NS)
`define POR_CNT_BITS 10

`endif

// File: rtl/pld_config_security_preload.sv
// Configuration store, security lock, bulk erase and register preload of the logic device
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "pld_cfg.svh"
module pld_config_security_preload (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Preload pins from the tester
    input wire logic PRELOAD_ENABLE,
    input wire logic PRELOAD_SERIAL_IN,
    input wire logic PRELOAD_CLOCK,
    output logic PRELOAD_SERIAL_OUT,
    output logic PRELOAD_SERIAL_OUT_OE,
    // Common registered output enable pin, active low
    input wire logic OUT_ENABLE_N,
    // Sum terms from the logic array, same clock
    input wire logic [`CELLS-1:0] REG_D,
    input wire logic [`CELLS-1:0] COMB_D,
    input wire logic [`CELLS-1:0] COMB_OE,
    // Output pins
    output logic [`CELLS-1:0] OUT_PIN_O,
    output logic [`CELLS-1:0] OUT_PIN_OE
);

    // All state of the block, current and next
    pld_pkg::core_state_s s_reg;
    pld_pkg::core_state_s s_next;

    // Decoded configuration and synchronised pin events
    logic por_active;
    logic [`CELLS-1:0] reg_mask;
    logic [`CELLS-1:0] polarity;
    logic [`CELLS-1:0] q_shifted;
    logic chain_out;
    pld_pkg::cell_mode_e mode;
    logic preload_on;
    logic pclk_rise;
    logic oe_pin_n;

    // Merge a write under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] res;

        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end

        return res;
    endfunction

    // Device mode from the sync and ac0 bits
    function automatic pld_pkg::cell_mode_e decode_mode(input logic [`CW_BITS-1:0] cw);
        if (!cw[`CW_SYNC] && cw[`CW_AC0]) begin
            return pld_pkg::MODE_REGISTERED;
        end else if (cw[`CW_SYNC] && cw[`CW_AC0]) begin
            return pld_pkg::MODE_COMPLEX;
        end else begin
            return pld_pkg::MODE_SIMPLE;
        end
    endfunction

    // Readable value of a register offset
    function automatic logic [31:0] reg_read(input pld_pkg::core_state_s st,
                                             input logic por, input logic pre,
                                             input logic regm, input logic [7:0] adr);
        logic [31:0] v;

        v = 32'h0;
        case (adr)
            `OFS_ROW: v[`ROW_BITS-1:0] = st.row;
            `OFS_DATA0: v = st.data_in[0];
            `OFS_DATA1: v = st.data_in[1];
            `OFS_DATA2: v[`CW_BITS-65:0] = st.data_in[2][`CW_BITS-65:0];
            `OFS_RDATA0: v = st.data_out[0];
            `OFS_RDATA1: v = st.data_out[1];
            `OFS_RDATA2: v = st.data_out[2];
            `OFS_STATUS: begin
                v[`ST_LOCK] = st.lock;
                v[`ST_DENIED] = st.denied;
                v[`ST_BAD_ROW] = st.bad_row;
                v[`ST_POR] = por;
                v[`ST_PRELOAD] = pre;
                v[`ST_REG_MODE] = regm;
            end
            `OFS_OUTS: v[2*`CELLS-1:0] = {st.pin, st.q};
            default: v = 32'h0;
        endcase

        return v;
    endfunction

    // Offset is one of the mapped registers
    function automatic logic mapped(input logic [7:0] adr);
        case (adr)
            `OFS_ROW, `OFS_DATA0, `OFS_DATA1, `OFS_DATA2, `OFS_CMD,
            `OFS_RDATA0, `OFS_RDATA1, `OFS_RDATA2, `OFS_STATUS, `OFS_OUTS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Power-up reset timer
    por_reset u_por (
        .clk(CLK),
        .rst(RST),
        .active(por_active)
    );

    // Preload shift chain over registered cells
    preload_chain u_chain (
        .reg_mask(reg_mask),
        .q(s_reg.q),
        .serial_in(s_reg.sync2[1]),
        .q_shifted(q_shifted),
        .serial_out(chain_out)
    );

    // Configuration decode from the control word
    always_comb begin
        mode = decode_mode(s_reg.ctrl_word);
        polarity = s_reg.ctrl_word[`CW_POL_LSB +: `CELLS];
        if (mode == pld_pkg::MODE_REGISTERED) begin
            reg_mask = ~s_reg.ctrl_word[`CW_CELL_LSB +: `CELLS];
        end else begin
            reg_mask = '0;
        end
    end

    // Synchronised pin levels and preload clock edge
    assign preload_on = s_reg.sync2[0];
    assign oe_pin_n = s_reg.sync2[3];
    assign pclk_rise = s_reg.sync2[2] && !s_reg.pclk_prev;

    // Next state of bus, store and output registers
    always_comb begin
        logic [31:0] wv;
        logic [`CELLS-1:0] qn;
        logic [`CW_BITS-1:0] wide;

        s_next = s_reg;
        wv = 32'h0;
        qn = s_reg.q;
        wide = {s_reg.data_in[2][`CW_BITS-65:0], s_reg.data_in[1], s_reg.data_in[0]};

        // Pin synchronisers
        s_next.sync1 = {OUT_ENABLE_N, PRELOAD_CLOCK, PRELOAD_SERIAL_IN, PRELOAD_ENABLE};
        s_next.sync2 = s_reg.sync1;
        s_next.pclk_prev = s_reg.sync2[2];

        // Write address and data taken in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            s_next.aw_have = 1'b1;
            s_next.aw_addr = S_AXI_AWADDR;
        end

        if (S_AXI_WVALID && S_AXI_WREADY) begin
            s_next.w_have = 1'b1;
            s_next.w_data = S_AXI_WDATA;
            s_next.w_strb = S_AXI_WSTRB;
        end

        // Response leaves once the master has taken it
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            s_next.bvalid = 1'b0;
        end

        // Register write once both halves are held
        if (s_reg.aw_have && s_reg.w_have) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = mapped(s_reg.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;

            // Writes to read-only offsets fall through to an error answer
            case (s_reg.aw_addr)
                `OFS_ROW: begin
                    wv = merge({26'h0, s_reg.row}, s_reg.w_data, s_reg.w_strb);
                    s_next.row = wv[`ROW_BITS-1:0];
                end
                `OFS_DATA0: s_next.data_in[0] = merge(s_reg.data_in[0], s_reg.w_data,
                                                      s_reg.w_strb);
                `OFS_DATA1: s_next.data_in[1] = merge(s_reg.data_in[1], s_reg.w_data,
                                                      s_reg.w_strb);
                `OFS_DATA2: begin
                    wv = merge(s_reg.data_in[2], s_reg.w_data, s_reg.w_strb);
                    s_next.data_in[2] = {14'h0, wv[`CW_BITS-65:0]};
                end
                `OFS_CMD: begin
                    // Program wins when both command bits are set
                    if (s_reg.w_strb[0] && s_reg.w_data[`CMD_PROGRAM]) begin
                        s_next.bad_row = 1'b0;
                        if (s_reg.row < `ROW_BITS'(`ARRAY_ROWS)) begin
                            s_next.array_rows[s_reg.row] = wide[`ARRAY_BITS-1:0];
                        end else if (s_reg.row == `ROW_SIGNATURE) begin
                            s_next.signature = wide[`ARRAY_BITS-1:0];
                        end else if (s_reg.row == `ROW_CTRL) begin
                            s_next.ctrl_word = wide;
                        end else if (s_reg.row == `ROW_LOCK) begin
                            // Programming can only set the lock, never clear it
                            s_next.lock = s_reg.lock | wide[0];
                        end else if (s_reg.row == `ROW_ERASE) begin
                            // Lock goes only together with every other row
                            s_next.array_rows = {`ARRAY_ROWS{`ERASED_ROW}};
                            s_next.signature = `ERASED_ROW;
                            s_next.ctrl_word = `ERASED_CW;
                            s_next.lock = 1'b0;
                        end else begin
                            s_next.bad_row = 1'b1;
                        end
                    end else if (s_reg.w_strb[0] && s_reg.w_data[`CMD_READ]) begin
                        // Read-back result lands in the three result words
                        s_next.denied = 1'b0;
                        s_next.bad_row = 1'b0;
                        wide = '0;

                        if (s_reg.row < `ROW_BITS'(`ARRAY_ROWS)) begin
                            if (s_reg.lock) begin
                                s_next.denied = 1'b1;
                            end else begin
                                wide[`ARRAY_BITS-1:0] = s_reg.array_rows[s_reg.row];
                            end
                        end else if (s_reg.row == `ROW_SIGNATURE) begin
                            wide[`ARRAY_BITS-1:0] = s_reg.signature;
                        end else if (s_reg.row == `ROW_CTRL) begin
                            wide = s_reg.ctrl_word;
                        end else if (s_reg.row == `ROW_LOCK) begin
                            wide[0] = s_reg.lock;
                        end else begin
                            s_next.bad_row = 1'b1;
                        end

                        // The 82-bit result spreads over three words
                        s_next.data_out[0] = wide[31:0];
                        s_next.data_out[1] = wide[63:32];
                        s_next.data_out[2] = {14'h0, wide[`CW_BITS-1:64]};
                    end
                end
                default: s_next.bresp = s_reg.bresp | `RESP_SLVERR;
            endcase
        end

        // Read channel answers the cycle after the address is taken
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            s_next.rvalid = 1'b0;
        end

        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = reg_read(s_reg, por_active, preload_on,
                                    mode == pld_pkg::MODE_REGISTERED, S_AXI_ARADDR);
            s_next.rresp = mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
        end

        // Output registers: held clear in reset, preload or normal capture
        if (por_active) begin
            qn = '0;
        end else if (preload_on) begin
            if (pclk_rise) begin
                qn = q_shifted;
            end
        end else begin
            // Polarity applied before the register, so a cleared register
            // always shows high at the pin
            qn = (s_reg.q & ~reg_mask) | ((REG_D ^ ~polarity) & reg_mask);
        end

        s_next.q = qn;

        // Pin values and enables: registered cells from the next register contents and the enable pin, others from the array terms
        for (int i = 0; i < `CELLS; i++) begin
            if (reg_mask[i]) begin
                s_next.pin[i] = ~qn[i];
                s_next.pin_oe[i] = !oe_pin_n;
            end else begin
                s_next.pin[i] = COMB_D[i] ^ polarity[i];
                s_next.pin_oe[i] = COMB_OE[i];
            end
        end

        // Serial buffers open only while preload is enabled
        s_next.sout_oe = preload_on;
        s_next.sout = preload_on ? chain_out : 1'b0;
    end

    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            // Store erased, pins high, bus idle
            s_reg <= '0;
            s_reg.array_rows <= {`ARRAY_ROWS{`ERASED_ROW}};
            s_reg.signature <= `ERASED_ROW;
            s_reg.ctrl_word <= `ERASED_CW;
            s_reg.row <= `ROW_RESET;
            s_reg.pin <= `PIN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Bus handshake outputs
    assign S_AXI_AWREADY = !s_reg.aw_have && !s_reg.bvalid;
    assign S_AXI_WREADY = !s_reg.w_have && !s_reg.bvalid;
    assign S_AXI_BVALID = s_reg.bvalid;
    assign S_AXI_BRESP = s_reg.bresp;

    // Read side handshake and data
    assign S_AXI_ARREADY = !s_reg.rvalid;
    assign S_AXI_RVALID = s_reg.rvalid;
    assign S_AXI_RDATA = s_reg.rdata;
    assign S_AXI_RRESP = s_reg.rresp;

    // Pin outputs
    assign OUT_PIN_O = s_reg.pin;
    assign OUT_PIN_OE = s_reg.pin_oe;
    assign PRELOAD_SERIAL_OUT = s_reg.sout;
    assign PRELOAD_SERIAL_OUT_OE = s_reg.sout_oe;

endmodule

// File: rtl/pld_pkg.sv
// Types of the configuration, security and preload logic
`include "pld_cfg.svh"
package pld_pkg;

    typedef enum logic [1:0] {
        MODE_SIMPLE,
        MODE_COMPLEX,
        MODE_REGISTERED
    } cell_mode_e;

    typedef struct packed {
        logic [`POR_CNT_BITS-1:0] count;
        logic active;
    } por_state_s;

    typedef struct packed {
        logic [`ARRAY_ROWS-1:0][`ARRAY_BITS-1:0] array_rows;
        logic [`ARRAY_BITS-1:0] signature;
        logic [`CW_BITS-1:0] ctrl_word;
        logic lock;
        logic [`ROW_BITS-1:0] row;
        logic [2:0][31:0] data_in;
        logic [2:0][31:0] data_out;
        logic denied;
        logic bad_row;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic pclk_prev;
        logic [`CELLS-1:0] q;
        logic [`CELLS-1:0] pin;
        logic [`CELLS-1:0] pin_oe;
        logic sout;
        logic sout_oe;
    } core_state_s;

endpackage

// File: rtl/por_reset.sv
// Power-up reset timer holding the registers cleared after power-up
`timescale 1ns/1ps
`include "pld_cfg.svh"
module por_reset (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Reset still in progress
    output logic active
);

    pld_pkg::por_state_s state_reg;
    pld_pkg::por_state_s state_next;

    // Count the reset time, then release
    always_comb begin
        state_next = state_reg;
        if (state_reg.active) begin
            if (state_reg.count == `POR_CNT_BITS'(`POR_CYCLES - 1)) begin
                state_next.active = 1'b0;
            end else begin
                state_next.count = state_reg.count + `POR_CNT_BITS'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{count: '0, active: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign active = state_reg.active;

endmodule

// File: rtl/preload_chain.sv
// Serial preload shift through the registered macrocells only
`timescale 1ns/1ps
`include "pld_cfg.svh"
module preload_chain (
    // Chain membership and current register contents
    input wire logic [`CELLS-1:0] reg_mask,
    input wire logic [`CELLS-1:0] q,
    input wire logic serial_in,
    // Shifted contents and bit leaving the chain
    output logic [`CELLS-1:0] q_shifted,
    output logic serial_out
);

    // Bit enters the bottom cell, existing bits move upward
    always_comb begin
        logic carry;
        carry = serial_in;
        q_shifted = q;
        for (int i = 0; i < `CELLS; i++) begin
            if (reg_mask[i]) begin
                q_shifted[i] = carry;
                carry = q[i];
            end
        end
        serial_out = carry;
    end

endmodule

// File: testbench/pld_config_security_preload_properties.sv
// Bus handshake and preload pin properties of the configuration block
`timescale 1ns/1ps
module pld_config_security_preload_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Write channels
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // Read channels
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Preload pins
    input wire logic PRELOAD_ENABLE,
    input wire logic PRELOAD_SERIAL_OUT,
    input wire logic PRELOAD_SERIAL_OUT_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Steps of a write and of the preload pin settling through its synchroniser
    sequence s_write_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_pe_on;
        PRELOAD_ENABLE [*4];
    endsequence
    sequence s_pe_off;
        (!PRELOAD_ENABLE) [*4];
    endsequence
    a_write_answer: assert property (s_write_taken |-> ##2 S_AXI_BVALID)
        else $error("write response missing");
    a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data missing");
    a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    a_read_blocks: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address accepted while data pending");
    a_write_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    a_serial_open: assert property (s_pe_on |-> PRELOAD_SERIAL_OUT_OE)
        else $error("serial buffer closed in preload");
    a_serial_closed: assert property (s_pe_off |->
        !PRELOAD_SERIAL_OUT_OE && !PRELOAD_SERIAL_OUT) else $error("serial buffer open");
endmodule
bind pld_config_security_preload pld_config_security_preload_checker u_chk (
    .CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .PRELOAD_ENABLE(PRELOAD_ENABLE), .PRELOAD_SERIAL_OUT(PRELOAD_SERIAL_OUT),
    .PRELOAD_SERIAL_OUT_OE(PRELOAD_SERIAL_OUT_OE));

// File: testbench/pld_config_security_preload_tb_top.sv
// Self-checking bench of the configuration, lock, erase and preload block
`timescale 1ns/1ps
`include "pld_cfg.svh"
module pld_config_security_preload_tb_top;
    logic CLK, RST, awvalid, wvalid, bready, arvalid, rready, oe_n;
    logic awready, wready, bvalid, arready, rvalid, pe, psi, pck, pso, pso_oe;
    logic [7:0] awaddr, araddr, reg_d, comb_d, comb_oe, pin_o, pin_oe, qv, cd, co, rv;
    logic [31:0] wdata, rdata, sig0, sig1, arr0, arr1, pol;
    logic [1:0] bresp, rresp;
    logic [2:0] bits;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    int miscompares, num_checks;
    pld_config_security_preload u_dut (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .PRELOAD_ENABLE(pe), .PRELOAD_SERIAL_IN(psi),
        .PRELOAD_CLOCK(pck), .PRELOAD_SERIAL_OUT(pso), .PRELOAD_SERIAL_OUT_OE(pso_oe),
        .OUT_ENABLE_N(oe_n), .REG_D(reg_d), .COMB_D(comb_d), .COMB_OE(comb_oe),
        .OUT_PIN_O(pin_o), .OUT_PIN_OE(pin_oe));
    preload_tester u_tester (.clk(CLK), .enable(pe), .serial_in(psi), .pclk(pck));
    // Clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Comparison of one value
    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Bus write; the expected response goes into the queue
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_d, w_d, aw_h, w_h;
        aw_d = 1'b0;
        w_d = 1'b0;
        bq.push_back(a > 8'h24 ? `RESP_SLVERR : `RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(negedge CLK);
            aw_h = awvalid && awready;
            w_h = wvalid && wready;
            @(posedge CLK);
            if (aw_h) begin
                awvalid <= 1'b0;
                aw_d = 1'b1;
            end
            if (w_h) begin
                wvalid <= 1'b0;
                w_d = 1'b1;
            end
        end
        repeat ($urandom_range(0, 2)) @(posedge CLK);
        bready <= 1'b1;
        do @(negedge CLK); while (!bvalid);
        @(posedge CLK);
        bready <= 1'b0;
    endtask
    // Bus read; the expected masked data and response go into the queue
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, (a > 8'h24) ? `RESP_SLVERR : `RESP_OKAY, e & m});
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge CLK); while (!arready);
        @(posedge CLK);
        arvalid <= 1'b0;
        repeat ($urandom_range(0, 2)) @(posedge CLK);
        rready <= 1'b1;
        do @(negedge CLK); while (!rvalid);
        @(posedge CLK);
        rready <= 1'b0;
    endtask
    // Row program and row read commands
    task automatic prog(input logic [5:0] row, input logic [31:0] d0, d1, d2);
        wr(`OFS_ROW, {26'h0, row});
        wr(`OFS_DATA0, d0);
        wr(`OFS_DATA1, d1);
        wr(`OFS_DATA2, d2);
        wr(`OFS_CMD, 32'h1);
    endtask
    task automatic rd_row(input logic [5:0] row, input logic [31:0] e0, e1);
        wr(`OFS_ROW, {26'h0, row});
        wr(`OFS_CMD, 32'h2);
        rd(`OFS_RDATA0, e0, 32'hFFFFFFFF);
        rd(`OFS_RDATA1, e1, 32'hFFFFFFFF);
    endtask
    // Response watcher: each answer is compared with the oldest note
    always @(negedge CLK) begin
        logic [65:0] n;
        if (bvalid && bready) begin
            check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
        end
        if (rvalid && rready) begin
            n = rq.pop_front();
            check("rdata", {rresp, rdata & n[65:34]}, n[33:0]);
        end
    end
    // Random logic array terms
    always @(posedge CLK) begin
        reg_d <= 8'($urandom);
        comb_d <= 8'($urandom);
        comb_oe <= 8'($urandom);
    end
    // Main sequence
    initial begin
        RST = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, oe_n} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        void'($urandom(32'hF2418401));
        repeat (10) @(posedge CLK);
        check("reset pins", {26'h0, pin_o}, {26'h0, `PIN_RESET});
        RST <= 1'b0;
        @(posedge CLK);
        rd(`OFS_STATUS, 32'h8, 32'hFFFFFFFF);
        repeat (`POR_CYCLES) @(posedge CLK);
        rd(`OFS_STATUS, 32'h0, 32'hFFFFFFFF);
        sig0 = $urandom;
        sig1 = $urandom;
        arr0 = $urandom;
        arr1 = $urandom;
        prog(`ROW_SIGNATURE, sig0, sig1, 32'h0);
        prog(6'h27, arr0, arr1, 32'h0);
        rd_row(6'h27, arr0, arr1);
        prog(`ROW_LOCK, 32'h1, 32'h0, 32'h0);
        rd_row(6'h27, 32'h0, 32'h0);
        rd(`OFS_STATUS, 32'h3, 32'hFFFFFFFF);
        prog(`ROW_LOCK, 32'h0, 32'h0, 32'h0);
        rd_row(`ROW_SIGNATURE, sig0, sig1);
        rd(`OFS_STATUS, 32'h1, 32'hFFFFFFFF);
        wr(8'h28, 32'hFFFFFFFF);
        rd(8'h28, 32'h0, 32'hFFFFFFFF);
        prog(`ROW_ERASE, 32'h0, 32'h0, 32'h0);
        rd(`OFS_STATUS, 32'h0, 32'hFFFFFFFF);
        rd_row(6'h27, 32'h0, 32'h0);
        rd_row(`ROW_SIGNATURE, 32'h0, 32'h0);
        pol = $urandom;
        prog(`ROW_CTRL, 32'h0, 32'h0, {14'h0, 2'b01, 8'hDA, pol[7:0]});
        rd(`OFS_STATUS, 32'h20, 32'hFFFFFFFF);
        oe_n <= 1'b1;
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        {rv, cd, co} = {reg_d, comb_d, comb_oe};
        @(negedge CLK);
        qv = ((rv & 8'h25) | (cd & 8'hDA)) ^ pol[7:0];
        check("pins", {26'h0, pin_o}, {26'h0, qv});
        check("pin oe", {26'h0, pin_oe}, {26'h0, co & 8'hDA});
        @(posedge CLK);
        oe_n <= 1'b0;
        bits = 3'($urandom);
        u_tester.set_mode(1'b1);
        for (int i = 0; i < 3; i++) begin
            u_tester.shift(bits[i]);
        end
        qv = {2'b00, bits[0], 2'b00, bits[1], 1'b0, bits[2]};
        rd(`OFS_STATUS, 32'h30, 32'hFFFFFFFF);
        rd(`OFS_OUTS, {16'h0, ~qv, qv}, 32'h2525);
        @(negedge CLK);
        check("serial out", {33'h0, pso}, {33'h0, bits[0]});
        check("reg enables", {26'h0, pin_oe & 8'h25}, 34'h25);
        check("serial oe", {33'h0, pso_oe}, 34'h1);
        u_tester.set_mode(1'b0);
        stop_test();
    end
    // Watchdog
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule

// File: testbench/preload_tester.sv
// Tester model driving the serial preload pins of the device
`timescale 1ns/1ps
module preload_tester (
    // Clock
    input wire logic clk,
    // Preload pins toward the device
    output logic enable,
    output logic serial_in,
    output logic pclk
);
    // Idle pins at power-up
    initial begin
        enable = 1'b0;
        serial_in = 1'b0;
        pclk = 1'b0;
    end
    // Enter or leave preload mode, then let the synchroniser settle
    task automatic set_mode(input logic on);
        @(posedge clk);
        enable <= on;
        repeat (6) @(posedge clk);
    endtask
    // One bit per preload clock rise, data held across the edge
    task automatic shift(input logic b);
        @(posedge clk);
        serial_in <= b;
        repeat (4) @(posedge clk);
        pclk <= 1'b1;
        repeat (4) @(posedge clk);
        pclk <= 1'b0;
        serial_in <= ~b;
        repeat (4) @(posedge clk);
    endtask
endmodule
